// >>> common/amsl_pkg.sv
// Package with constants and types of the alarm mask and signal loss block.
// Overview of operation
// [R01] Two 16-bit alarm words, warning and conflict.
// [R02] Status bit is 1 while condition present.
// [R03] Warnings never trip or stop the drive.
// [R04] Conflict alarm present refuses start commands.
// [R05] Two-wire plus three-wire inputs raise conflict.
// [R06] One mask bit per warning alarm.
// [R07] Conflict alarms always pass, never masked.
// [R08] Mask bit n governs status bit n.
// [R09] Set mask bit passes, cleared bit blocks.
// [R10] Active alarm sets status bit 6, routable.
// [R11] Active alarm shown on operator display panel.
// [R12] Mask bits reset to all ones.
// [R13] Masking leaves alarm status bit untouched.
// [R14] Loss below 1V or 2mA.
// [R15] Loss ends at 1.5V or 3mA.
// [R16] Loss action codes zero to six.
// [R17] Hold input keeps last value, raises warning.
// [R18] Reference selector decode, reserved codes ignored; the code stores them and gives a zero reference.
// [R19] Config bit 0 (input 1) and bit 1 (input 2) select current mode.
// [R20] Input scaling points map onto frequency points.
// [R21] Linear interpolation; summary is OR of gated alarms.
// [R22] Default selector value is a configurable constant.
package amsl_pkg;
  localparam logic [7:0] ALM1_OFS = 8'h00;
  localparam logic [7:0] ALM2_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] DSTAT_OFS = 8'h0c;
  localparam logic [7:0] DIN_CFG_OFS = 8'h10;
  localparam logic [7:0] AIN_CFG_OFS = 8'h14;
  localparam logic [7:0] REF_SEL_OFS = 8'h18;
  localparam logic [7:0] DOUT_SEL_OFS = 8'h1c;
  localparam logic [7:0] AIN1_SCL_OFS = 8'h20;
  localparam logic [7:0] AIN2_SCL_OFS = 8'h24;
  localparam logic [7:0] FRQ_SCL_OFS = 8'h28;
  localparam logic [7:0] SPD_REF_OFS = 8'h2c;
  localparam logic [7:0] CTRL_OFS = 8'h30;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [15:0] MASK_RST = 16'hffff;
  localparam logic [4:0] REF_SEL_RST = 5'h01;
  localparam logic [3:0] DOUT_SEL_RST = 4'h6;
  localparam logic [15:0] AIN_LO_RST = 16'h0000;
  localparam logic [15:0] AIN_HI_RST = 16'h2710;
  localparam logic [15:0] FRQ_LO_RST = 16'h0000;
  localparam logic [15:0] FRQ_HI_RST = 16'h1770;
  localparam int DST_READY = 0;
  localparam int DST_RUN = 1;
  localparam int DST_START_BLK = 2;
  localparam int DST_ALARM = 6;
  localparam int DST_FAULT = 7;
  localparam int ALM1_AIN1 = 0;
  localparam int ALM1_AIN2 = 1;
  localparam int ALM2_DIN_CONFLICT = 0;
  localparam int AIN_CUR1 = 0;
  localparam int AIN_CUR2 = 1;
  localparam int AIN_ACT1 = 4;
  localparam int AIN_ACT2 = 8;
  localparam int CTRL_FCLR = 0;
  localparam int NUM_DIN = 6;
  localparam logic [1:0] DIN_TWO_WIRE = 2'h1;
  localparam logic [1:0] DIN_THREE_WIRE = 2'h2;
  // Levels are millivolts in voltage mode and microamps in current mode.
  localparam logic [15:0] LOSS_ENTER_MV = 16'h03e8;
  localparam logic [15:0] LOSS_EXIT_MV = 16'h05dc;
  localparam logic [15:0] LOSS_ENTER_UA = 16'h07d0;
  localparam logic [15:0] LOSS_EXIT_UA = 16'h0bb8;
  localparam logic [4:0] SEL_AIN1 = 5'h01;
  localparam logic [4:0] SEL_AIN2 = 5'h02;
  localparam logic [4:0] SEL_PULSE = 5'h07;
  localparam logic [4:0] SEL_ENC = 5'h08;
  localparam logic [4:0] SEL_MOP = 5'h09;
  localparam logic [4:0] SEL_PRE_LO = 5'h0b;
  localparam logic [4:0] SEL_PRE_HI = 5'h11;
  localparam logic [4:0] SEL_NET_LO = 5'h12;
  localparam logic [4:0] SEL_NET_HI = 5'h16;
  typedef enum logic [2:0] {
    LOSS_OFF = 3'h0, LOSS_FAULT = 3'h1, LOSS_HOLD_IN = 3'h2, LOSS_SET_LO = 3'h3,
    LOSS_SET_HI = 3'h4, LOSS_PRESET1 = 3'h5, LOSS_HOLD_FRQ = 3'h6
  } amsl_loss_e;
  typedef struct packed {
    logic [15:0] pulse;
    logic [15:0] encoder;
    logic [15:0] motor_operated_pot_level;
    logic [6:0][15:0] preset;
    logic [4:0][15:0] network_reference_port;
  } amsl_src_s;
  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } amsl_scale_s;
  typedef struct packed {
    logic loss;
    logic warn;
    logic fault;
    logic preset1;
    logic hold_freq;
    logic [15:0] value;
  } amsl_loss_s;
  typedef struct packed {
    logic loss_q;
    logic [15:0] last_q;
    amsl_loss_s out_q;
  } amsl_det_s;
  typedef struct packed {
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic ph_valid_q;
    logic ph_write_q;
    logic [7:0] ph_addr_q;
    logic [15:0] alm1_q;
    logic [15:0] alm2_q;
    logic [15:0] mask_q;
    logic [15:0] dstat_q;
    logic [11:0] din_cfg_q;
    logic [10:0] ain_cfg_q;
    logic [4:0] ref_sel_q;
    logic [3:0] dout_sel_q;
    amsl_scale_s ain1_scl_q;
    amsl_scale_s ain2_scl_q;
    amsl_scale_s frq_scl_q;
    logic [15:0] speed_ref_q;
    logic run_q;
    logic fault_q;
    logic dout_q;
    logic panel_q;
  } amsl_regs_s;
endpackage

// >>> rtl/amsl_loss_det.sv
// Signal loss detector with hysteresis and loss action for one analog input.
`timescale 1ns/10ps
module amsl_loss_det
  import amsl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [15:0] level,
  input wire logic cur_mode,
  input wire logic [2:0] action,
  input wire amsl_scale_s scale,
  output amsl_loss_s result
);
  amsl_det_s q;
  amsl_det_s d;
  logic [15:0] enter_lvl;
  logic [15:0] exit_lvl;
  amsl_loss_e act;

  assign act = amsl_loss_e'(action);
  assign enter_lvl = cur_mode ? LOSS_ENTER_UA : LOSS_ENTER_MV; // [R19] [R14]
  assign exit_lvl = cur_mode ? LOSS_EXIT_UA : LOSS_EXIT_MV; // [R15]

  always_comb
  begin
    d = q;
    // The loss state leaves only at the higher threshold, so noise near 1V/2mA cannot chatter.
    if (q.loss_q)
      d.loss_q = level < exit_lvl; // [R15]
    else
      d.loss_q = level < enter_lvl; // [R14]
    if (!d.loss_q)
      d.last_q = level;
    d.out_q.loss = d.loss_q;
    d.out_q.value = level;
    d.out_q.warn = 1'b0;
    d.out_q.fault = 1'b0;
    d.out_q.preset1 = 1'b0;
    d.out_q.hold_freq = 1'b0;
    if (d.loss_q)
    begin
      unique case (act) // [R16]
        LOSS_OFF: d.out_q.value = level;
        LOSS_FAULT: d.out_q.fault = 1'b1;
        LOSS_HOLD_IN: d.out_q.value = q.last_q; // [R17]
        LOSS_SET_LO: d.out_q.value = scale.lo;
        LOSS_SET_HI: d.out_q.value = scale.hi;
        LOSS_PRESET1: d.out_q.preset1 = 1'b1;
        LOSS_HOLD_FRQ: d.out_q.hold_freq = 1'b1;
        default: d.out_q.value = level;
      endcase
      d.out_q.warn = (act >= LOSS_HOLD_IN) && (act <= LOSS_HOLD_FRQ); // [R17]
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= '0;
    else
      q <= d;
  end

  assign result = q.out_q;
endmodule

// >>> rtl/amsl_top.sv
// Alarm status, mask, signal loss and speed reference block with AHB-Lite registers.
`timescale 1ns/10ps
module amsl_top
  import amsl_pkg::*;
#(
  parameter logic [4:0] REF_SEL_DEFAULT = REF_SEL_RST // [R22]
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [15:0] ain1_level,
  input wire logic [15:0] ain2_level,
  input wire amsl_src_s ref_src,
  input wire logic [15:0] warn_cond,
  input wire logic [15:0] conflict_cond,
  input wire logic start_req,
  input wire logic stop_req,
  output logic run,
  output logic faulted,
  output logic alarm_dout,
  output logic operator_display_panel,
  output logic [15:0] speed_ref
);
  // ----------------------------------------------------------------
  // State and loss detectors
  // ----------------------------------------------------------------
  amsl_regs_s q;
  amsl_regs_s d;
  amsl_loss_s ln1;
  amsl_loss_s ln2;
  logic [31:0] rd_mux;
  logic two_wire;
  logic three_wire;
  logic active;
  logic is_ain;
  amsl_loss_s sel_ln;
  amsl_scale_s sel_scl;
  logic [15:0] x;
  logic [15:0] dx;
  logic [15:0] span;
  logic signed [16:0] df;
  logic signed [33:0] num;
  logic signed [33:0] quo;
  logic [15:0] interp;

  amsl_loss_det u_loss1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .level(ain1_level),
    .cur_mode(q.ain_cfg_q[AIN_CUR1]),
    .action(q.ain_cfg_q[AIN_ACT1 +: 3]),
    .scale(q.ain1_scl_q),
    .result(ln1)
  );

  amsl_loss_det u_loss2 (
    .hclk(hclk),
    .hresetn(hresetn),
    .level(ain2_level),
    .cur_mode(q.ain_cfg_q[AIN_CUR2]),
    .action(q.ain_cfg_q[AIN_ACT2 +: 3]),
    .scale(q.ain2_scl_q),
    .result(ln2)
  );

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_mux = '0;
    unique case (q.ph_addr_q)
      ALM1_OFS: rd_mux[15:0] = q.alm1_q;
      ALM2_OFS: rd_mux[15:0] = q.alm2_q;
      MASK_OFS: rd_mux[15:0] = q.mask_q;
      DSTAT_OFS: rd_mux[15:0] = q.dstat_q;
      DIN_CFG_OFS: rd_mux[11:0] = q.din_cfg_q;
      AIN_CFG_OFS: rd_mux[10:0] = q.ain_cfg_q;
      REF_SEL_OFS: rd_mux[4:0] = q.ref_sel_q;
      DOUT_SEL_OFS: rd_mux[3:0] = q.dout_sel_q;
      AIN1_SCL_OFS: rd_mux = q.ain1_scl_q;
      AIN2_SCL_OFS: rd_mux = q.ain2_scl_q;
      FRQ_SCL_OFS: rd_mux = q.frq_scl_q;
      SPD_REF_OFS: rd_mux[15:0] = q.speed_ref_q;
      default: rd_mux = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Alarm gathering
  // ----------------------------------------------------------------
  always_comb
  begin
    two_wire = 1'b0;
    three_wire = 1'b0;
    for (int i = 0; i < NUM_DIN; i++)
    begin
      if (q.din_cfg_q[2*i +: 2] == DIN_TWO_WIRE)
        two_wire = 1'b1;
      if (q.din_cfg_q[2*i +: 2] == DIN_THREE_WIRE)
        three_wire = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Speed reference interpolation
  // ----------------------------------------------------------------
  always_comb
  begin
    is_ain = (q.ref_sel_q == SEL_AIN1) || (q.ref_sel_q == SEL_AIN2);
    sel_ln = (q.ref_sel_q == SEL_AIN2) ? ln2 : ln1;
    sel_scl = (q.ref_sel_q == SEL_AIN2) ? q.ain2_scl_q : q.ain1_scl_q;
    x = sel_ln.value;
    if (x < sel_scl.lo)
      x = sel_scl.lo;
    if (x > sel_scl.hi)
      x = sel_scl.hi;
    dx = x - sel_scl.lo;
    span = sel_scl.hi - sel_scl.lo;
    df = $signed({1'b0, q.frq_scl_q.hi}) - $signed({1'b0, q.frq_scl_q.lo});
    num = $signed({1'b0, dx}) * df;
    quo = '0;
    interp = q.frq_scl_q.lo;
    // A degenerate span would divide by zero, so it pins the output to the low frequency.
    if (sel_scl.hi > sel_scl.lo)
    begin
      quo = num / $signed({18'h00000, span}); // [R21]
      interp = q.frq_scl_q.lo + quo[15:0]; // [R20]
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    active = 1'b0;

    // Register writes land in the data phase of the accepted transfer.
    if (q.ph_valid_q && q.ph_write_q)
    begin
      unique case (q.ph_addr_q)
        MASK_OFS: d.mask_q = hwdata[15:0]; // [R06] [R08]
        DIN_CFG_OFS: d.din_cfg_q = hwdata[11:0];
        AIN_CFG_OFS: d.ain_cfg_q = hwdata[10:0]; // [R19] [R16]
        REF_SEL_OFS: d.ref_sel_q = hwdata[4:0];
        DOUT_SEL_OFS: d.dout_sel_q = hwdata[3:0]; // [R10]
        AIN1_SCL_OFS: d.ain1_scl_q = hwdata;
        AIN2_SCL_OFS: d.ain2_scl_q = hwdata;
        FRQ_SCL_OFS: d.frq_scl_q = hwdata;
        CTRL_OFS: d.fault_q = q.fault_q & ~hwdata[CTRL_FCLR];
        default: d.mask_q = q.mask_q;
      endcase
    end

    // Reads take one wait state so that the answer leaves a flip-flop.
    d.ph_valid_q = 1'b0;
    if (q.ph_valid_q && !q.ph_write_q && !q.hreadyout_q)
    begin
      d.hrdata_q = rd_mux;
      d.hreadyout_q = 1'b1;
    end
    if (hsel && htrans[1] && hready && (hsize == HSIZE_WORD))
    begin
      d.ph_valid_q = 1'b1;
      d.ph_write_q = hwrite;
      d.ph_addr_q = haddr[7:0];
      d.hreadyout_q = hwrite;
    end

    // Status bits follow the live conditions; the mask never touches them.
    d.alm1_q = warn_cond; // [R01] [R02] [R13]
    d.alm1_q[ALM1_AIN1] = warn_cond[ALM1_AIN1] | ln1.warn; // [R17]
    d.alm1_q[ALM1_AIN2] = warn_cond[ALM1_AIN2] | ln2.warn;
    d.alm2_q = conflict_cond; // [R01] [R02]
    d.alm2_q[ALM2_DIN_CONFLICT] = conflict_cond[ALM2_DIN_CONFLICT] | (two_wire & three_wire); // [R05]

    // Warnings pass only through their mask bit, conflicts always pass.
    active = (|d.alm2_q) | (|(d.alm1_q & q.mask_q)); // [R07] [R09] [R21]

    // Only a loss action of fault trips; warnings feed nothing here.
    if (ln1.fault || ln2.fault) // [R03]
      d.fault_q = 1'b1;

    if (d.fault_q || stop_req)
      d.run_q = 1'b0;
    else if (start_req && !(|d.alm2_q)) // [R04]
      d.run_q = 1'b1;

    d.dstat_q = '0;
    d.dstat_q[DST_READY] = !d.fault_q && !(|d.alm2_q);
    d.dstat_q[DST_RUN] = d.run_q;
    d.dstat_q[DST_START_BLK] = |d.alm2_q; // [R04]
    d.dstat_q[DST_ALARM] = active; // [R10]
    d.dstat_q[DST_FAULT] = d.fault_q;
    d.dout_q = d.dstat_q[q.dout_sel_q]; // [R10]
    d.panel_q = active; // [R11]

    // Reserved selector codes give a zero reference.
    d.speed_ref_q = '0; // [R18]
    if (is_ain)
    begin
      if (sel_ln.preset1)
        d.speed_ref_q = ref_src.preset[0]; // [R16]
      else if (sel_ln.hold_freq)
        d.speed_ref_q = q.speed_ref_q; // [R16]
      else
        d.speed_ref_q = interp; // [R20]
    end
    else if (q.ref_sel_q == SEL_PULSE)
      d.speed_ref_q = ref_src.pulse; // [R18]
    else if (q.ref_sel_q == SEL_ENC)
      d.speed_ref_q = ref_src.encoder;
    else if (q.ref_sel_q == SEL_MOP)
      d.speed_ref_q = ref_src.motor_operated_pot_level;
    else if ((q.ref_sel_q >= SEL_PRE_LO) && (q.ref_sel_q <= SEL_PRE_HI))
      d.speed_ref_q = ref_src.preset[3'(q.ref_sel_q - SEL_PRE_LO)]; // [R18]
    else if ((q.ref_sel_q >= SEL_NET_LO) && (q.ref_sel_q <= SEL_NET_HI))
      d.speed_ref_q = ref_src.network_reference_port[3'(q.ref_sel_q - SEL_NET_LO)]; // [R18]
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.hreadyout_q <= 1'b1;
      q.mask_q <= MASK_RST; // [R12]
      q.ref_sel_q <= REF_SEL_DEFAULT; // [R22]
      q.dout_sel_q <= DOUT_SEL_RST;
      q.ain1_scl_q <= {AIN_HI_RST, AIN_LO_RST};
      q.ain2_scl_q <= {AIN_HI_RST, AIN_LO_RST};
      q.frq_scl_q <= {FRQ_HI_RST, FRQ_LO_RST};
    end
    else
    begin
      q <= d;
    end
  end

  assign hreadyout = q.hreadyout_q;
  assign hrdata = q.hrdata_q;
  assign hresp = 1'b0;
  assign run = q.run_q;
  assign faulted = q.fault_q;
  assign alarm_dout = q.dout_q;
  assign operator_display_panel = q.panel_q;
  assign speed_ref = q.speed_ref_q;
endmodule

// >>> verification/amsl_sensor_model.sv
// Analog sensor and alarm lamp model at the far side of the block.
`timescale 1ns/10ps
module amsl_sensor_model
(
  input wire logic hclk,
  input wire logic [15:0] tgt1,
  input wire logic [15:0] tgt2,
  input wire logic alarm_dout,
  output logic [15:0] ain1_level,
  output logic [15:0] ain2_level,
  output logic [7:0] lamp_cnt
);
  logic dout_q;
  initial
  begin
    ain1_level = 16'h1388;
    ain2_level = 16'h1388;
    lamp_cnt = 8'h0;
    dout_q = 1'b0;
  end
  // The converter trails the sensor by one sample, so level steps are never instantaneous.
  always @(posedge hclk)
  begin
    ain1_level <= tgt1;
    ain2_level <= tgt2;
    dout_q <= alarm_dout;
    if (alarm_dout && !dout_q)
      lamp_cnt <= lamp_cnt + 8'h1;
  end
endmodule

// >>> verification/amsl_top_monitor.sv
// Concurrent checks on the ports of the alarm mask and signal loss block.
`timescale 1ns/10ps
module amsl_top_monitor
  import amsl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [15:0] conflict_cond,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic run,
  input wire logic faulted,
  input wire logic operator_display_panel
);
  logic taken;
  assign taken = hsel && htrans[1] && hready && (hsize == HSIZE_WORD);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_rd;
    taken && !hwrite;
  endsequence
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_read_wait;
    s_rd |=> s_rd_wait;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state wrong");
  property p_no_wait;
    (!taken || hwrite) && hreadyout |=> hreadyout;
  endproperty
  a_no_wait: assert property (p_no_wait)
    else $error("unexpected wait state");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay)
    else $error("response not okay");
  property p_conflict_panel;
    conflict_cond != 16'h0 |=> operator_display_panel;
  endproperty
  a_conflict_panel: assert property (p_conflict_panel)
    else $error("conflict not on panel");
  property p_conflict_start;
    conflict_cond != 16'h0 && !run |=> !run;
  endproperty
  a_conflict_start: assert property (p_conflict_start)
    else $error("start taken during conflict");
  property p_run_cause;
    $rose(run) |-> $past(start_req) && ($past(conflict_cond) == 16'h0);
  endproperty
  a_run_cause: assert property (p_run_cause)
    else $error("run without valid start");
  property p_warn_no_stop;
    run && !stop_req |=> run || faulted;
  endproperty
  a_warn_no_stop: assert property (p_warn_no_stop)
    else $error("run dropped without stop or fault");
  property p_stop_wins;
    stop_req |=> !run;
  endproperty
  a_stop_wins: assert property (p_stop_wins)
    else $error("run survived stop");
endmodule
bind amsl_top amsl_top_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .conflict_cond(conflict_cond), .start_req(start_req), .stop_req(stop_req), .run(run),
  .faulted(faulted), .operator_display_panel(operator_display_panel));

// >>> verification/test_amsl_top.sv
// Testbench of the alarm mask and signal loss block.
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; $display("Error %0t: got %h exp %h", $time, (a), (e)); end end
module test_amsl_top
  import amsl_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hwrite = 1'b0;
  logic start_req = 1'b0;
  logic stop_req = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] warn_cond = 16'h0;
  logic [15:0] conflict_cond = 16'h0;
  logic [15:0] tgt1 = 16'h1388;
  logic [15:0] tgt2 = 16'h1388;
  amsl_src_s ref_src = '0;
  logic hreadyout, hresp, run, faulted, alarm_dout, operator_display_panel;
  logic [31:0] hrdata, rd;
  logic [15:0] ain1_level, ain2_level, speed_ref;
  logic [7:0] lamp_cnt;
  logic [15:0] lv [8] = '{16'd1999, 16'd2999, 16'd3000, 16'd2000, 16'd999, 16'd1499, 16'd1500, 16'd1000};
  logic [15:0] sp [7] = '{16'h0, 16'h0, 16'h0bb8, 16'h0, 16'h1770, 16'h010b, 16'h0bb8};
  int error_cnt = 0;
  int checks = 0;
  amsl_top DUT (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hrdata, .hresp, .ain1_level, .ain2_level, .ref_src, .warn_cond, .conflict_cond, .start_req,
    .stop_req, .run, .faulted, .alarm_dout, .operator_display_panel, .speed_ref);
  amsl_sensor_model u_sensor (.hclk, .tgt1, .tgt2, .alarm_dout, .ain1_level, .ain2_level, .lamp_cnt);
  // --------
  // Tasks
  // --------
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic drv(input logic [15:0] l);
    @(posedge hclk);
    tgt1 <= l;
    cyc(5);
  endtask
  task automatic cmd(input logic s, input logic p);
    @(posedge hclk);
    start_req <= s;
    stop_req <= p;
    @(posedge hclk);
    start_req <= 1'b0;
    stop_req <= 1'b0;
    cyc(2);
  endtask
  task automatic results();
    $display("Checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // --------
  // Clock, watchdog and tests
  // --------
  initial
  begin
    forever #2 hclk = ~hclk;
  end
  // The whole sequence needs about 500 cycles; the margin covers slow bus answers.
  initial
  begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    results();
  end
  initial
  begin
    ref_src.pulse = 16'h0107;
    ref_src.encoder = 16'h0108;
    ref_src.motor_operated_pot_level = 16'h0109;
    for (int i = 0; i < 7; i++)
      ref_src.preset[i] = 16'h010b + 16'(i);
    for (int i = 0; i < 5; i++)
      ref_src.network_reference_port[i] = 16'h0112 + 16'(i);
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(MASK_OFS, 32'hffff);
    rdc(REF_SEL_OFS, 32'h1);
    rdc(ALM2_OFS, 32'h0);
    rdc(8'h40, 32'h0);
    warn_cond <= 16'h0004;
    wr(MASK_OFS, 32'hfff7);
    cyc(2);
    `CHK(operator_display_panel, 1'b1)
    `CHK(alarm_dout, 1'b1)
    xfer(1'b0, DSTAT_OFS, 32'h0);
    `CHK(rd[DST_ALARM], 1'b1)
    cmd(1'b1, 1'b0);
    `CHK(run, 1'b1)
    wr(MASK_OFS, 32'hfffb);
    cyc(2);
    `CHK(operator_display_panel, 1'b0)
    rdc(ALM1_OFS, 32'h4);
    `CHK(lamp_cnt, 8'h1)
    cmd(1'b0, 1'b1);
    warn_cond <= 16'h0;
    conflict_cond <= 16'h0008;
    wr(MASK_OFS, 32'h0);
    cyc(2);
    `CHK(operator_display_panel, 1'b1)
    rdc(ALM2_OFS, 32'h8);
    cmd(1'b1, 1'b0);
    `CHK(run, 1'b0)
    conflict_cond <= 16'h0;
    wr(DIN_CFG_OFS, 32'h9);
    rdc(ALM2_OFS, 32'h1);
    cmd(1'b1, 1'b0);
    `CHK(run, 1'b0)
    wr(DIN_CFG_OFS, 32'h0);
    wr(MASK_OFS, 32'hffff);
    for (int s = 3; s < 24; s++)
    begin
      wr(REF_SEL_OFS, 32'(s));
      cyc(3);
      `CHK(speed_ref, (s inside {[7:9], [11:22]}) ? 16'h0100 + 16'(s) : 16'h0)
    end
    wr(REF_SEL_OFS, 32'h1);
    wr(AIN1_SCL_OFS, 32'h4e200fa0);
    wr(FRQ_SCL_OFS, 32'h17700000);
    wr(AIN_CFG_OFS, 32'h1);
    drv(16'd4000);
    `CHK(speed_ref, 16'h0)
    drv(16'd20000);
    `CHK(speed_ref, 16'h1770)
    drv(16'd12000);
    `CHK(speed_ref, 16'h0bb8)
    for (int c = 0; c < 7; c++)
    begin
      wr(AIN_CFG_OFS, 32'h1 | (32'(c) << 4));
      drv(16'd1000);
      `CHK(faulted, c == 1)
      xfer(1'b0, ALM1_OFS, 32'h0);
      `CHK(rd[ALM1_AIN1], c > 1)
      if (c != 1)
        `CHK(speed_ref, sp[c])
      drv(16'd12000);
      wr(CTRL_OFS, 32'h1);
    end
    `CHK(faulted, 1'b0)
    wr(AIN_CFG_OFS, 32'h21);
    for (int i = 0; i < 8; i++)
    begin
      if (i == 4)
        wr(AIN_CFG_OFS, 32'h20);
      drv(lv[i]);
      xfer(1'b0, ALM1_OFS, 32'h0);
      `CHK(rd[ALM1_AIN1], (i % 4) < 2)
    end
    // The second input drives the reference, then loses its signal under hold input; a run bit is routed out.
    wr(REF_SEL_OFS, 32'h2);
    cyc(3);
    rdc(SPD_REF_OFS, 32'h0bb8);
    wr(AIN_CFG_OFS, 32'h220);
    @(posedge hclk);
    tgt2 <= 16'd500;
    cyc(5);
    rdc(ALM1_OFS, 32'h2);
    `CHK(speed_ref, 16'h0bb8)
    `CHK(operator_display_panel, 1'b1)
    `CHK(alarm_dout, 1'b1)
    wr(DOUT_SEL_OFS, 32'h1);
    cyc(2);
    `CHK(alarm_dout, 1'b0)
    rdc(DOUT_SEL_OFS, 32'h1);
    rdc(DSTAT_OFS, 32'h41);
    results();
  end
endmodule
